// ===== rtl/tsfm_params.svh
`ifndef TSFM_PARAMS_SVH
`define TSFM_PARAMS_SVH
// -----------------------------------------
// timing
// -----------------------------------------
`define CLK_PERIOD_NS 20
`define NS_PER_MS 1000000
`define FLASH_SLOT_MS 500
`define SLOT_CYCLES (`FLASH_SLOT_MS * `NS_PER_MS / `CLK_PERIOD_NS)
`define RETRY_S 8'h1e
`define PTDL_OFF_S 8'h00
`define DIGIT_GAP_SLOTS 4'h2
`define REPEAT_GAP_SLOTS 4'h6
`define HIST_DEPTH 50
// -----------------------------------------
// register map (byte addresses)
// -----------------------------------------
`define REG_CTRL 8'h00
`define REG_PTDL 8'h04
`define REG_CDLY 8'h08
`define REG_STATUS 8'h0c
`define REG_HIST_SEL 8'h10
`define REG_HIST_DATA 8'h14
`define CTRL_XFER_BIT 0
`define CTRL_RETX_BIT 1
`define CTRL_PT_EN_BIT 2
`define PTDL_RST 8'h05
`define CDLY_RST 8'h0a
// -----------------------------------------
// event codes, decimal digits packed bcd
// -----------------------------------------
`define CODE_CHECKSUM 16'h0343
`define CODE_BATT_LOW 16'h0441
`define CODE_FTC_XFER 16'h1113
`define CODE_FTC_RETX 16'h1114
`define CODE_CHARGER 16'h0597
`define CODE_NET_BATT 16'h0477
`define CODE_NET_COMM 16'h1468
`define CODE_XFER_DONE 16'h0101
`define CODE_RETX_DONE 16'h0102
`define CODE_ENG_STOP 16'h0103
`endif

// ===== rtl/tsfm_pkg.sv
package tsfm_pkg;
  // sequencer steps
  typedef enum logic [2:0] {S_IDLE, S_TO_NEUTRAL, S_PTDL, S_TO_DEST, S_RETRY, S_COOLDOWN} seq_e;
  // flash-out steps
  typedef enum logic [2:0] {F_IDLE, F_ON, F_OFF, F_GAP, F_REP} flash_e;
  // synchronised pin group
  typedef struct packed {
    logic s1_limit;
    logic s2_limit;
    logic neutral_limit;
    logic s2_avail;
    logic batt_low;
    logic charger_fault;
    logic net_batt_low;
    logic net_comm_fail;
    logic reset_sw;
  } pin_in_s;
  // relay drives
  typedef struct packed {
    logic transfer;
    logic retransfer;
    logic prog_trans;
    logic engine_run;
  } relay_s;
  // indicators and display
  typedef struct packed {
    logic status;
    logic ptdl;
    logic s1_connected;
    logic s2_connected;
    logic s2_available;
    logic asterisk;
  } lamp_s;
  // one history record
  typedef struct packed {
    logic is_fault;
    logic [15:0] code;
  } hist_s;
endpackage

// ===== rtl/transfer_switch_fault_manager.sv
// Summary of operation
// - no programmed transition means zero delay
// - delay expiry energizes transition relay, stops blink
// - source 1 lamp follows source 1 limit
// - cool-down timer starts once source 1 loaded
// - cool-down expiry stops engine, source 2 lamp
// - each record keeps fault or non-fault class
// - last 50 events readable through the history registers
// - fail-to-close codes 1113 and 1114
// - codes 343, 441 and 597
// - network codes 477 and 1468
// - flash active fault until reset switch
// - digit blink groups, short and long pauses
// - acknowledged events go to 50-entry history
// - asterisk shown until reset acknowledges
// - boot checksum compared with stored value
// - boot continues despite checksum fault
// - battery comparator input raises low fault
// - retransfer moves timed, fault on overrun
// - transfer moves timed, fault on overrun
// - retry closure every 30 seconds
// - fail-to-close stays until reset switch
// - charger event follows charger input
// - half hertz heartbeat when nothing pending
//
// The AXI4-Lite register port and the address map were chosen for this implementation.
`include "tsfm_params.svh"
`timescale 1ns/1ps
`default_nettype none
module transfer_switch_fault_manager #(
  parameter int SLOT_CYCLES = `SLOT_CYCLES,
  parameter int PROG_WORDS = 256,
  parameter int AW = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // axi4-lite slave
  input wire logic [AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // field pins, asynchronous
  input wire tsfm_pkg::pin_in_s pins,
  // program memory and configuration storage
  output logic [15:0] prog_addr,
  input wire logic [15:0] prog_data,
  input wire logic [15:0] nvm_checksum,
  input wire logic [7:0] cfg_ftc_limit,
  // outputs
  output tsfm_pkg::relay_s relays,
  output tsfm_pkg::lamp_s lamps,
  output logic [15:0] disp_code
);
  import tsfm_pkg::*;
  localparam int NEV = 10;
  // -----------------------------------------
  // pin synchronisers
  // -----------------------------------------
  localparam int NP = $bits(pin_in_s);
  logic [NP-1:0] meta; // first stage, read by second only
  logic [NP-1:0] syn;
  pin_in_s p;
  pin_in_s p_d; // previous sample for edges
  // two flops per pin
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta <= '0;
      syn <= '0;
      p_d <= '0;
    end else begin
      meta <= pins;
      syn <= meta;
      p_d <= p;
    end
  end
  assign p = pin_in_s'(syn);
  wire ack_press = p.reset_sw & ~p_d.reset_sw;
  // -----------------------------------------
  // slot and second ticks
  // -----------------------------------------
  logic [31:0] pre; // half-second prescaler
  logic half; // second-tick divider
  wire slot_tick = (pre == 32'(SLOT_CYCLES - 1));
  wire sec_tick = slot_tick & half;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pre <= '0;
      half <= 1'b0;
    end else begin
      pre <= slot_tick ? '0 : pre + 32'h1;
      half <= half ^ slot_tick;
    end
  end
  // -----------------------------------------
  // boot checksum
  // -----------------------------------------
  logic booting;
  logic [15:0] sum;
  logic [7:0] ftc_limit;
  wire last_word = (prog_addr == 16'(PROG_WORDS - 1));
  wire boot_end = booting & last_word;
  wire [15:0] sum_final = sum + prog_data;
  // sums program words; sequencer is never held back by a mismatch
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      booting <= 1'b1;
      prog_addr <= '0;
      sum <= '0;
      ftc_limit <= 8'h00;
    end else if (booting) begin
      sum <= sum_final;
      prog_addr <= last_word ? prog_addr : prog_addr + 16'h1;
      booting <= ~last_word;
      if (last_word) ftc_limit <= cfg_ftc_limit;
    end
  end
  // -----------------------------------------
  // register bus
  // -----------------------------------------
  logic [AW-1:0] aw_addr;
  logic aw_have, w_have;
  logic [31:0] w_data;
  logic pt_en;
  logic [7:0] ptdl_s, cdly_s;
  logic [5:0] hist_sel;
  logic cmd_xfer, cmd_retx;
  wire wr_go = aw_have & w_have & ~s_axi_bvalid;
  wire [7:0] wa = 8'(aw_addr);
  wire [7:0] ra = 8'(s_axi_araddr);
  wire wr_hit = wa == `REG_CTRL || wa == `REG_PTDL || wa == `REG_CDLY || wa == `REG_HIST_SEL;
  assign s_axi_awready = ~aw_have & ~s_axi_bvalid;
  assign s_axi_wready = ~w_have & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  // write side: address and data taken in either order
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      aw_have <= 1'b0;
      w_have <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end else begin
      if (s_axi_awvalid & s_axi_awready) begin
        aw_have <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_have <= 1'b1;
        w_data <= s_axi_wdata;
      end
      if (wr_go) begin
        aw_have <= 1'b0;
        w_have <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? 2'b00 : 2'b11; // unmapped: decode error
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  // register stores; only byte lane 0 carries data
  wire wr_l0 = wr_go & s_axi_wstrb[0];
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pt_en <= 1'b1;
      ptdl_s <= `PTDL_RST;
      cdly_s <= `CDLY_RST;
      hist_sel <= '0;
      cmd_xfer <= 1'b0;
      cmd_retx <= 1'b0;
    end else begin
      cmd_xfer <= wr_l0 && wa == `REG_CTRL && w_data[`CTRL_XFER_BIT];
      cmd_retx <= wr_l0 && wa == `REG_CTRL && w_data[`CTRL_RETX_BIT];
      if (wr_l0 && wa == `REG_CTRL) pt_en <= w_data[`CTRL_PT_EN_BIT];
      if (wr_l0 && wa == `REG_PTDL) ptdl_s <= w_data[7:0];
      if (wr_l0 && wa == `REG_CDLY) cdly_s <= w_data[7:0];
      if (wr_l0 && wa == `REG_HIST_SEL) hist_sel <= w_data[5:0];
    end
  end
  // -----------------------------------------
  // transfer sequencer
  // -----------------------------------------
  seq_e st;
  logic dir; // 1: retransfer to source 1
  logic phase2; // retry returns to destination move
  logic [7:0] tmr; // seconds in current step
  logic ftc_x, ftc_r, done_x, done_r, eng_stop;
  wire dest_lim = dir ? p.s1_limit : p.s2_limit;
  wire [7:0] pt_len = pt_en ? ptdl_s : `PTDL_OFF_S;
  wire ftc_over = sec_tick && tmr >= ftc_limit;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= S_IDLE;
      dir <= 1'b0;
      phase2 <= 1'b0;
      tmr <= '0;
      relays <= '0;
      {ftc_x, ftc_r, done_x, done_r, eng_stop} <= '0;
    end else begin
      {ftc_x, ftc_r, done_x, done_r, eng_stop} <= '0;
      tmr <= sec_tick ? tmr + 8'h1 : tmr;
      case (st)
        S_IDLE: begin
          tmr <= '0;
          if (cmd_xfer | cmd_retx) begin
            dir <= cmd_retx;
            phase2 <= 1'b0;
            relays.engine_run <= relays.engine_run | cmd_xfer;
            st <= S_TO_NEUTRAL;
          end
        end
        S_TO_NEUTRAL: begin
          relays.transfer <= ~dir;
          relays.retransfer <= dir;
          if (p.neutral_limit) begin
            {relays.transfer, relays.retransfer} <= '0;
            tmr <= '0;
            st <= S_PTDL;
          end else if (ftc_over) begin
            ftc_x <= ~dir;
            ftc_r <= dir;
            {relays.transfer, relays.retransfer} <= '0;
            tmr <= '0;
            st <= S_RETRY;
          end
        end
        S_PTDL: if (tmr >= pt_len) begin
          tmr <= '0;
          phase2 <= 1'b1;
          st <= S_TO_DEST;
        end
        S_TO_DEST: begin
          relays.prog_trans <= 1'b1;
          if (dest_lim) begin
            relays.prog_trans <= 1'b0;
            tmr <= '0;
            done_x <= ~dir;
            done_r <= dir;
            st <= dir ? S_COOLDOWN : S_IDLE;
          end else if (ftc_over) begin
            ftc_x <= ~dir;
            ftc_r <= dir;
            relays.prog_trans <= 1'b0;
            tmr <= '0;
            st <= S_RETRY;
          end
        end
        S_RETRY: if (sec_tick && tmr >= `RETRY_S - 8'h1) begin
          tmr <= '0;
          st <= phase2 ? S_TO_DEST : S_TO_NEUTRAL;
        end
        S_COOLDOWN: if (tmr >= cdly_s) begin
          relays.engine_run <= 1'b0;
          eng_stop <= 1'b1;
          st <= S_IDLE;
        end
        default: st <= S_IDLE;
      endcase
    end
  end
  // -----------------------------------------
  // fault status
  // -----------------------------------------
  logic [6:0] active; // fault is present
  logic [6:0] pend; // not yet acknowledged
  logic [6:0] lvl, raise;
  logic chk_bad;
  assign chk_bad = boot_end && sum_final != nvm_checksum;
  assign lvl = {p.net_comm_fail, p.net_batt_low, p.charger_fault, 2'b00, p.batt_low, 1'b0};
  assign raise = {p.net_comm_fail & ~p_d.net_comm_fail, p.net_batt_low & ~p_d.net_batt_low,
    p.charger_fault & ~p_d.charger_fault, ftc_r, ftc_x, p.batt_low & ~p_d.batt_low, chk_bad};
  // reset switch clears what is no longer driven; a new raise wins
  always_ff @(posedge clk or posedge rst) begin
    if (rst) active <= '0;
    else begin
      active <= (active & ~{7{ack_press}}) | raise | lvl;
      active[4] <= p.charger_fault;
    end
  end
  // -----------------------------------------
  // event codes
  // -----------------------------------------
  function automatic logic [15:0] ev_code(input logic [3:0] i);
    case (i)
      4'h0: ev_code = `CODE_CHECKSUM;
      4'h1: ev_code = `CODE_BATT_LOW;
      4'h2: ev_code = `CODE_FTC_XFER;
      4'h3: ev_code = `CODE_FTC_RETX;
      4'h4: ev_code = `CODE_CHARGER;
      4'h5: ev_code = `CODE_NET_BATT;
      4'h6: ev_code = `CODE_NET_COMM;
      4'h7: ev_code = `CODE_XFER_DONE;
      4'h8: ev_code = `CODE_RETX_DONE;
      default: ev_code = `CODE_ENG_STOP;
    endcase
  endfunction
  // -----------------------------------------
  // acknowledge and history logging
  // -----------------------------------------
  logic ack_busy; // draining acknowledged faults
  logic [2:0] nf; // non-fault events awaiting a slot
  logic [NEV-1:0] req;
  logic [3:0] pick;
  logic pick_ok;
  assign req = {nf, pend & {7{ack_busy}}};
  // lowest requester wins; one record per cycle
  always_comb begin
    pick = 4'h0;
    pick_ok = 1'b0;
    for (int i = NEV - 1; i >= 0; i--) begin
      if (req[i]) begin
        pick = 4'(i);
        pick_ok = 1'b1;
      end
    end
  end
  wire [NEV-1:0] grant = pick_ok ? NEV'(1) << pick : '0;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pend <= '0;
      nf <= '0;
      ack_busy <= 1'b0;
    end else begin
      pend <= (pend & ~grant[6:0]) | raise;
      nf <= (nf & ~grant[9:7]) | {eng_stop, done_r, done_x};
      ack_busy <= ack_press | (ack_busy & |(pend & ~grant[6:0]));
    end
  end
  hist_s hist [`HIST_DEPTH];
  logic [5:0] wp;
  logic [5:0] hcnt;
  // circular store, oldest overwritten
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wp <= '0;
      hcnt <= '0;
    end else if (pick_ok) begin
      wp <= (wp == 6'(`HIST_DEPTH - 1)) ? '0 : wp + 6'h1;
      hcnt <= (hcnt == 6'(`HIST_DEPTH)) ? hcnt : hcnt + 6'h1;
    end
  end
  always_ff @(posedge clk) begin
    if (pick_ok) hist[wp] <= '{is_fault: pick < 4'h7, code: ev_code(pick)};
  end
  // index 0 is the newest record
  wire [6:0] rd_raw = 7'(wp) + 7'(`HIST_DEPTH - 1) - 7'(hist_sel);
  wire [6:0] rd_ix = rd_raw >= 7'(`HIST_DEPTH) ? rd_raw - 7'(`HIST_DEPTH) : rd_raw;
  wire sel_ok = hist_sel < hcnt;
  wire hist_s rd_ent = hist[6'(rd_ix)];
  // -----------------------------------------
  // read side
  // -----------------------------------------
  wire [31:0] rd_word =
    ra == `REG_CTRL ? 32'(pt_en) << `CTRL_PT_EN_BIT :
    ra == `REG_PTDL ? 32'(ptdl_s) :
    ra == `REG_CDLY ? 32'(cdly_s) :
    ra == `REG_STATUS ? {12'h000, ~booting, 1'(st), 1'b0, 2'(st >> 1), pend, 1'b0, active} :
    ra == `REG_HIST_SEL ? 32'(hist_sel) :
    ra == `REG_HIST_DATA ? (sel_ok ? {8'h00, 2'(hcnt >> 4), hcnt[3:0], 1'b1, rd_ent} : 32'h0) : 32'h0;
  wire rd_hit = ra <= `REG_HIST_DATA && ra[1:0] == 2'b00;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= 2'b00;
    end else if (s_axi_arvalid & s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_hit ? rd_word : 32'h0;
      s_axi_rresp <= rd_hit ? 2'b00 : 2'b11;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
  // -----------------------------------------
  // fault flash-out
  // -----------------------------------------
  flash_e fst;
  logic [15:0] fsh; // digits, current one on top
  logic [2:0] fnd; // digits left
  logic [3:0] fcnt;
  logic beat; // heartbeat phase
  logic [3:0] fpick;
  // lowest pending fault is the one flashed
  always_comb begin
    fpick = 4'h0;
    for (int i = 6; i >= 0; i--) if (pend[i]) fpick = 4'(i);
  end
  wire [15:0] fcode = ev_code(fpick);
  wire [2:0] ndig = fcode[15:12] != 4'h0 ? 3'h4 : fcode[11:8] != 4'h0 ? 3'h3 : 3'h2;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fst <= F_IDLE;
      fsh <= '0;
      fnd <= '0;
      fcnt <= '0;
      beat <= 1'b0;
    end else begin
      beat <= beat ^ sec_tick;
      if (~|pend) fst <= F_IDLE;
      else if (slot_tick) begin
        case (fst)
          F_IDLE: begin
            fsh <= fcode << (4 * (3'h4 - ndig));
            fcnt <= 4'((fcode << (4 * (3'h4 - ndig))) >> 12);
            fnd <= ndig;
            fst <= F_ON;
          end
          F_ON: begin
            fcnt <= fcnt - 4'h1;
            fst <= F_OFF;
          end
          F_OFF: if (fcnt != 4'h0) fst <= F_ON;
          else if (fnd > 3'h1) begin
            fsh <= fsh << 4;
            fnd <= fnd - 3'h1;
            fcnt <= `DIGIT_GAP_SLOTS;
            fst <= F_GAP;
          end else begin
            fcnt <= `REPEAT_GAP_SLOTS;
            fst <= F_REP;
          end
          F_GAP: begin
            fcnt <= fcnt == 4'h1 ? fsh[15:12] : fcnt - 4'h1;
            if (fcnt == 4'h1) fst <= F_ON;
          end
          F_REP: begin
            fcnt <= fcnt - 4'h1;
            if (fcnt == 4'h1) fst <= F_IDLE;
          end
          default: fst <= F_IDLE;
        endcase
      end
    end
  end
  // -----------------------------------------
  // indicators and display
  // -----------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lamps <= '0;
      disp_code <= '0;
    end else begin
      lamps.status <= |pend ? fst == F_ON : beat;
      lamps.ptdl <= st == S_PTDL && tmr < pt_len && beat;
      lamps.s1_connected <= p.s1_limit;
      lamps.s2_connected <= p.s2_limit;
      lamps.s2_available <= p.s2_avail & relays.engine_run;
      lamps.asterisk <= |pend;
      disp_code <= |pend ? fcode : 16'h0;
    end
  end
endmodule
`default_nettype wire

// ===== sim/tsfm_switch_model.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------
// switch mechanism: moves while a relay is held
// ------------------------------------
module tsfm_switch_model
  import tsfm_pkg::*;
#(
  parameter int MOVE_CYCLES = 3
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // drive side
  input wire tsfm_pkg::relay_s relays,
  input wire logic stuck,
  // limit contacts
  output logic s1_limit,
  output logic s2_limit,
  output logic neutral_limit
);
  logic [1:0] pos; // 0 source 1, 1 neutral, 2 source 2
  logic [1:0] dest; // where the next neutral exit goes
  logic [3:0] cnt; // travel time so far
  // a jammed switch ignores every relay
  wire go = !stuck && ((pos == 2'd0 && relays.transfer) || (pos == 2'd2 && relays.retransfer)
    || (pos == 2'd1 && relays.prog_trans));
  wire arrive = go && (cnt == 4'(MOVE_CYCLES - 1));
  // travel only while the relay stays energised
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pos <= 2'd0;
      dest <= 2'd2;
      cnt <= 4'h0;
    end else begin
      cnt <= (arrive || !go) ? 4'h0 : cnt + 4'h1;
      if (arrive) begin
        pos <= (pos == 2'd1) ? dest : 2'd1;
        dest <= (pos == 2'd0) ? 2'd2 : (pos == 2'd2) ? 2'd0 : dest;
      end
    end
  end
  // contacts open while travelling
  assign s1_limit = pos == 2'd0 && cnt == 4'h0;
  assign neutral_limit = pos == 2'd1 && cnt == 4'h0;
  assign s2_limit = pos == 2'd2 && cnt == 4'h0;
endmodule
`default_nettype wire

// ===== sim/tsfm_chk.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------
// port checker
// ------------------------------------
module tsfm_chk
  import tsfm_pkg::*;
#(
  parameter int SLOT_CYCLES = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // watched ports
  input wire tsfm_pkg::pin_in_s pins,
  input wire tsfm_pkg::relay_s relays,
  input wire tsfm_pkg::lamp_s lamps,
  input wire logic [15:0] disp_code
);
  logic [7:0] run_q; // cycles status lamp unchanged
  logic [7:0] idle_q; // cycles with nothing pending
  logic [7:0] busy_q; // cycles with a code pending
  // saturating counters so long runs never wrap
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      run_q <= 8'h00;
      idle_q <= 8'h00;
      busy_q <= 8'h00;
    end else begin
      run_q <= $changed(lamps.status) ? 8'h00 : run_q + 8'(run_q != 8'hff);
      idle_q <= (disp_code != 16'h0000) ? 8'h00 : idle_q + 8'(idle_q != 8'hff);
      busy_q <= (disp_code == 16'h0000) ? 8'h00 : busy_q + 8'(busy_q != 8'hff);
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // load back on source 1 with the engine still running
  sequence s1_landed;
    $rose(lamps.s1_connected) ##0 relays.engine_run;
  endsequence
  chk_asterisk_code: assert property (disp_code != 16'h0000 |-> lamps.asterisk)
    else $error("asterisk off while a code is pending");
  chk_code_legal: assert property (disp_code != 16'h0000 |-> disp_code inside {16'h0343, 16'h0441,
    16'h1113, 16'h1114, 16'h0597, 16'h0477, 16'h1468})
    else $error("unknown code shown");
  chk_prog_neutral: assert property ($rose(relays.prog_trans) |-> pins.neutral_limit)
    else $error("transition relay away from neutral");
  chk_ptdl_quiet: assert property (relays.prog_trans |-> !lamps.ptdl)
    else $error("delay lamp lit with transition relay on");
  chk_s1_lamp: assert property ($rose(pins.s1_limit) |-> ##[1:5] lamps.s1_connected)
    else $error("source 1 lamp late");
  chk_cool_hold: assert property (s1_landed |-> relays.engine_run [*6])
    else $error("engine stopped before cool-down");
  chk_stop_lamp: assert property ($fell(relays.engine_run) |-> ##[0:2] !lamps.s2_available)
    else $error("source 2 lamp still lit");
  chk_stop_at_s1: assert property ($fell(relays.engine_run) |-> lamps.s1_connected)
    else $error("engine stopped off source 1");
  chk_heart_rate: assert property (idle_q > 8'd24 |-> run_q < 8'(2 * SLOT_CYCLES))
    else $error("heartbeat too slow");
  chk_flash_slot: assert property (busy_q > 8'd16 && disp_code != 16'h0000 && $fell(lamps.status)
    |-> run_q == 8'(SLOT_CYCLES - 1))
    else $error("flash pulse not one slot");
endmodule
bind transfer_switch_fault_manager tsfm_chk #(.SLOT_CYCLES(SLOT_CYCLES)) chk_u (.clk(clk), .rst(rst),
  .pins(pins), .relays(relays), .lamps(lamps), .disp_code(disp_code));
`default_nettype wire

// ===== sim/transfer_switch_fault_manager_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------
// bench top
// ------------------------------------
module transfer_switch_fault_manager_tb_top;
  import tsfm_pkg::*;
  localparam int SLOT = 4; // short slot keeps the run brief
  localparam logic [15:0] fcode [4] = '{16'h0441, 16'h0597, 16'h0477, 16'h1468};
  localparam int fbit [4] = '{1, 4, 5, 6}; // status bit of each
  logic clk, rst, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr, araddr, ftc_limit;
  logic [31:0] wdata, rdata, rd_val;
  logic [1:0] bresp, rresp, rd_resp;
  logic [15:0] prog_addr, nvm_checksum, disp_code;
  logic [3:0] flt; // battery, charger, network battery, network link
  logic rsw, stuck, s1l, s2l, nl, ptdl_seen, prev;
  pin_in_s pins;
  relay_s relays;
  lamp_s lamps;
  int err_total, total_checks, cyc_cnt, falls;
  // generator always available
  assign pins = {s1l, s2l, nl, 1'b1, flt[0], flt[1], flt[2], flt[3], rsw};
  transfer_switch_fault_manager #(.SLOT_CYCLES(SLOT), .PROG_WORDS(8)) dut_u (.clk(clk), .rst(rst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .pins(pins), .prog_addr(prog_addr), .prog_data(prog_addr + 16'h0001),
    .nvm_checksum(nvm_checksum), .cfg_ftc_limit(ftc_limit), .relays(relays), .lamps(lamps),
    .disp_code(disp_code));
  tsfm_switch_model model_u (.clk(clk), .rst(rst), .relays(relays), .stuck(stuck), .s1_limit(s1l),
    .s2_limit(s2l), .neutral_limit(nl));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // hang guard and delay lamp watch
  always @(posedge clk) begin
    cyc_cnt <= cyc_cnt + 1;
    if (lamps.ptdl) ptdl_seen <= 1'b1;
    if (cyc_cnt == 20000) begin
      err_total++;
      finish_test();
    end
  end
  task automatic step(input int n);
    repeat (n) begin
      @(posedge clk);
      #1;
    end
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // write: address and data offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ah, wh, bh;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    bh = 1'b0;
    while (!bh) begin
      @(negedge clk);
      ah = awvalid && awready;
      wh = wvalid && wready;
      bh = bvalid;
      step(1);
      if (ah) awvalid <= 1'b0;
      if (wh) wvalid <= 1'b0;
    end
  endtask
  task automatic rd(input logic [7:0] a);
    logic ah, rh;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    rh = 1'b0;
    while (!rh) begin
      @(negedge clk);
      ah = arvalid && arready;
      rh = rvalid;
      rd_val = rdata;
      rd_resp = rresp;
      step(1);
      if (ah) arvalid <= 1'b0;
    end
  endtask
  // front-panel reset press
  task automatic ack();
    rsw <= 1'b1;
    step(6);
    rsw <= 1'b0;
    step(8);
  endtask
  task automatic hist_newest(input logic [15:0] code, input logic cls);
    wr(8'h10, 32'h0);
    rd(8'h14);
    check(32'(rd_val[17:0]), {14'h0, 1'b1, cls, code});
  endtask
  // jam the switch, let the fault land, then free it for the retry
  task automatic ftc(input logic [31:0] ctrl, input int b, input logic [15:0] code);
    stuck <= 1'b1;
    ptdl_seen <= 1'b0;
    wr(8'h00, ctrl);
    rd_val = 32'h0;
    while (rd_val[b] !== 1'b1) rd(8'h0c);
    check(32'(disp_code), 32'(code));
    stuck <= 1'b0;
    while ((ctrl[0] ? lamps.s2_connected : lamps.s1_connected) !== 1'b1) step(1);
    check(32'(relays.engine_run), 1);
    step(20);
    rd(8'h0c);
    check(32'(rd_val[b]), 1);
    ack();
    rd(8'h0c);
    check(32'({rd_val[b + 8], rd_val[b]}), 0);
    hist_newest(code, 1'b1);
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    {rst, awvalid, wvalid, bready, arvalid, rready, rsw, stuck, ptdl_seen} = 9'h100;
    {awaddr, araddr, wdata, flt} = '0;
    nvm_checksum = 16'h0025; // word sum is 0024, so boot must flag it
    ftc_limit = 8'h02;
    {err_total, total_checks, cyc_cnt} = '0;
    step(4);
    rst <= 1'b0;
    step(20);
    rd(8'h0c);
    check(32'({rd_val[19], rd_val[0]}), 3);
    check(32'(disp_code), 32'h0343);
    check(32'(lamps.asterisk), 1);
    step(40);
    falls = 0;
    // 3, 4, 3 pulses per pass of 31 slots
    repeat (31 * SLOT) begin
      prev = lamps.status;
      step(1);
      falls += int'(prev && !lamps.status);
    end
    check(falls, 10);
    ack();
    check(32'({disp_code, 15'h0, lamps.asterisk}), 0);
    hist_newest(16'h0343, 1'b1);
    rd(8'h04);
    check(rd_val, 32'h5);
    rd(8'h08);
    check(rd_val, 32'ha);
    rd(8'h18);
    check(32'(rd_resp), 32'h3);
    wr(8'h04, 32'h3);
    wr(8'h08, 32'h2);
    ptdl_seen <= 1'b0;
    wr(8'h00, 32'h5);
    while (lamps.s2_connected !== 1'b1) step(1);
    check(32'(ptdl_seen), 1);
    step(4);
    hist_newest(16'h0101, 1'b0);
    ftc(32'h2, 3, 16'h1114);
    check(32'(ptdl_seen), 0);
    while (relays.engine_run !== 1'b0) step(1);
    check(32'(lamps.s2_available), 0);
    ftc(32'h5, 2, 16'h1113);
    for (int k = 0; k < 4; k++) begin
      flt[k] <= 1'b1;
      step(10);
      rd(8'h0c);
      check(32'(rd_val[fbit[k]]), 1);
      check(32'(disp_code), 32'(fcode[k]));
      flt[k] <= 1'b0;
      step(10);
      rd(8'h0c);
      check(32'(rd_val[4]), 0);
      ack();
      check(32'(disp_code), 0);
    end
    step(40);
    finish_test();
  end
endmodule
`default_nettype wire
